// ===== core/smac_top.sv
// Segment access controller: translation, checks, table load, registers
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module smac_top (
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_cpu_req,
	input  wire logic [15:0] i_cpu_addr,
	input  wire logic [15:0] i_cpu_pc,
	input  wire smac_pkg::smac_mode_e i_cpu_mode,
	input  wire smac_pkg::smac_acc_e  i_cpu_kind,
	input  wire logic        i_cpu_sfr,
	input  wire logic [2:0]  i_cpu_grp,
	output logic             o_cpu_done,
	output var smac_pkg::smac_tgt_e   o_phys_tgt,
	output logic [15:0]      o_phys_addr,
	output logic             o_exc,
	output logic [15:0]      o_exc_vec,
	output logic             o_test_en,
	output logic             o_fetch_req,
	output logic [15:0]      o_fetch_addr,
	input  wire logic        i_fetch_ack,
	input  wire logic [31:0] i_fetch_data,
	input  wire logic        i_test_fuse,
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest
);
	import smac_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SCAN, ST_DECIDE}
		smac_st_e;

	typedef struct packed {
		smac_st_e   st;
		logic [6:0] widx;
		logic [6:0] ridx;
		logic [21:0] w0;
		logic [15:0] tbase;
		logic        loaded;
		logic [63:0] valid;
		logic        lock;
		logic        fuse_s1;
		logic        fuse_s2;
		logic [15:0] fault;
		logic        coll;
		logic        user;
		logic        hit_d;
		smac_desc_s  dsc;
		logic        hit_p;
		logic [7:0]  sfr_p;
		logic        done;
		smac_tgt_e   tgt;
		logic [15:0] pa;
		logic        exc;
		logic [15:0] vec;
		logic        test_en;
		logic        freq;
		logic [15:0] faddr;
		logic        wreq;
		logic [31:0] rdata;
	} smac_state_s;

	smac_state_s s_reg;
	smac_state_s s_next;
	smac_seg_if  seg ();

	smac_seg_mem #(.DEPTH(SMAC_SEG_NUM)) u_mem (
		.i_core_clk (i_core_clk),
		.seg        (seg)
	);

	// Page-granular window test, used for data address and code address
	function automatic logic seg_hit(input smac_desc_s d,
		input logic [15:0] va);
		logic [8:0] top;
		top = {1'b0, d.vpage} + {1'b0, d.npages};
		return d.en && ({1'b0, va[15:8]} >= {1'b0, d.vpage}) &&
			({1'b0, va[15:8]} < top);
	endfunction

	function automatic logic [15:0] region_size(input smac_tgt_e t);
		case (t)
			TGT_ROM: return SMAC_ROM_SIZE;
			TGT_EE:  return SMAC_EE_SIZE;
			TGT_RAM: return SMAC_RAM_SIZE;
			default: return 16'h0000;
		endcase
	endfunction

	// Segment translation and the checks on its result
	logic [16:0] seg_pa;
	logic        perm_ok;
	logic        mem_ok;
	logic        sfr_ok;
	logic        locked;
	logic        bus_req;
	logic        cfg_wr;
	logic        user_req;
	smac_desc_s  cur;
	logic [5:0]  cur_idx;

	assign locked   = s_reg.lock | s_reg.fuse_s2;
	assign bus_req  = (i_avs_read | i_avs_write) & s_reg.wreq;
	assign cfg_wr   = bus_req & i_avs_write & (i_cpu_mode == MODE_SYS);
	assign user_req = i_cpu_req & ~s_reg.done & (i_cpu_mode == MODE_USER);
	assign cur      = seg.rdata;
	assign cur_idx  = 6'(s_reg.ridx - 7'h01);
	assign seg_pa   = {1'b0, s_reg.dsc.pbase} + {1'b0, i_cpu_addr} -
		{1'b0, s_reg.dsc.vpage, 8'h00};
	always_comb begin
		case (i_cpu_kind)
			ACC_RD:  perm_ok = s_reg.dsc.rd;
			ACC_WR:  perm_ok = s_reg.dsc.wr;
			ACC_EX:  perm_ok = s_reg.dsc.ex;
			default: perm_ok = 1'b0;
		endcase
	end
	assign mem_ok = s_reg.hit_d && perm_ok &&
		(seg_pa < {1'b0, region_size(s_reg.dsc.tgt)}) &&
		!(s_reg.dsc.tgt == TGT_EE && seg_pa[15:0] >= SMAC_SEC_BASE);
	assign sfr_ok = s_reg.hit_p && s_reg.sfr_p[i_cpu_grp] &&
		(i_cpu_grp != SMAC_GRP_TEST);

	assign seg.raddr = s_reg.ridx[5:0];
	assign seg.we    = (s_reg.st == ST_LOAD) & i_fetch_ack & s_reg.widx[0];
	assign seg.waddr = s_reg.widx[6:1];
	assign seg.wdata = '{en: s_reg.w0[21], ex: s_reg.w0[20],
		wr: s_reg.w0[19], rd: s_reg.w0[18],
		tgt: smac_tgt_e'(s_reg.w0[17:16]), npages: s_reg.w0[15:8],
		vpage: s_reg.w0[7:0], pbase: i_fetch_data[15:0],
		sfr: i_fetch_data[23:16]};

	// Next-state logic for the whole controller
	always_comb begin
		s_next         = s_reg;
		s_next.done    = 1'b0;
		s_next.exc     = 1'b0;
		s_next.fuse_s1 = i_test_fuse;
		s_next.fuse_s2 = s_reg.fuse_s1;
		s_next.test_en = (i_cpu_mode == MODE_TEST) & ~locked;
		case (s_reg.st)
			ST_IDLE: begin
				if (i_cpu_req && !s_reg.done) begin
					s_next.user = (i_cpu_mode == MODE_USER);
					if (i_cpu_mode == MODE_USER) begin
						s_next.st    = ST_SCAN;
						s_next.ridx  = 7'h00;
						s_next.hit_d = 1'b0;
						s_next.hit_p = 1'b0;
					end else if (i_cpu_mode == MODE_TEST && locked) begin
						s_next.done  = 1'b1;
						s_next.exc   = 1'b1;
						s_next.vec   = SMAC_VEC_VIOL;
						s_next.coll  = 1'b0;
						s_next.fault = i_cpu_addr;
					end else begin
						s_next.done = 1'b1;
						s_next.pa   = {2'b00, i_cpu_addr[13:0]};
						if (i_cpu_sfr) begin
							s_next.tgt = TGT_NONE;
							s_next.pa  = i_cpu_addr;
						end else if (!i_cpu_addr[15]) begin
							s_next.tgt = TGT_ROM;
							s_next.pa  = {1'b0, i_cpu_addr[14:0]};
						end else if (!i_cpu_addr[14]) begin
							s_next.tgt = TGT_EE;
						end else begin
							s_next.tgt = TGT_RAM;
						end
					end
				end else if (cfg_wr && i_avs_address == SMAC_REG_CTRL &&
					i_avs_writedata[0]) begin
					s_next.st     = ST_LOAD;
					s_next.widx   = 7'h00;
					s_next.valid  = '0;
					s_next.loaded = 1'b0;
					s_next.freq   = 1'b1;
					s_next.faddr  = s_reg.tbase;
				end
			end
			ST_LOAD: begin
				if (user_req) begin
					s_next.done  = 1'b1;
					s_next.exc   = 1'b1;
					s_next.vec   = SMAC_VEC_COLL;
					s_next.coll  = 1'b1;
					s_next.fault = i_cpu_addr;
				end
				if (i_fetch_ack) begin
					s_next.widx  = s_reg.widx + 7'h01;
					s_next.faddr = s_reg.faddr + SMAC_WORD_STEP;
					if (!s_reg.widx[0]) begin
						s_next.w0 = i_fetch_data[21:0];
					end else begin
						s_next.valid[s_reg.widx[6:1]] = 1'b1;
					end
					if (s_reg.widx == 7'(SMAC_WORDS - 1)) begin
						s_next.st     = ST_IDLE;
						s_next.freq   = 1'b0;
						s_next.loaded = 1'b1;
					end
				end
			end
			ST_SCAN: begin
				s_next.ridx = s_reg.ridx + 7'h01;
				if (s_reg.ridx != 7'h00 && s_reg.valid[cur_idx]) begin
					if (!s_reg.hit_d && seg_hit(cur, i_cpu_addr)) begin
						s_next.hit_d = 1'b1;
						s_next.dsc   = cur;
					end
					if (!s_reg.hit_p && seg_hit(cur, i_cpu_pc)) begin
						s_next.hit_p = 1'b1;
						s_next.sfr_p = cur.sfr;
					end
				end
				if (s_reg.ridx == 7'(SMAC_SEG_NUM)) begin
					s_next.st = ST_DECIDE;
				end
			end
			ST_DECIDE: begin
				s_next.st   = ST_IDLE;
				s_next.done = 1'b1;
				if (i_cpu_sfr ? sfr_ok : mem_ok) begin
					s_next.tgt = i_cpu_sfr ? TGT_NONE : s_reg.dsc.tgt;
					s_next.pa  = i_cpu_sfr ? i_cpu_addr : seg_pa[15:0];
				end else begin
					s_next.exc   = 1'b1;
					s_next.vec   = SMAC_VEC_VIOL;
					s_next.coll  = 1'b0;
					s_next.fault = i_cpu_addr;
				end
			end
			default: s_next.st = ST_IDLE;
		endcase
		// Bus slave: one answer cycle after the request is seen
		s_next.wreq   = ~bus_req;
		if (bus_req && i_avs_read) begin
			case (i_avs_address)
				SMAC_REG_TBASE: s_next.rdata = {16'h0000, s_reg.tbase};
				SMAC_REG_STAT:  s_next.rdata = {28'h0000000, s_reg.coll,
					locked, s_reg.loaded, s_reg.st == ST_LOAD};
				SMAC_REG_FAULT: s_next.rdata = {16'h0000, s_reg.fault};
				default:        s_next.rdata = 32'h00000000;
			endcase
		end
		if (cfg_wr && i_avs_address == SMAC_REG_TBASE &&
			s_reg.st != ST_LOAD) begin
			s_next.tbase = i_avs_writedata[15:0];
		end
		if (cfg_wr && i_avs_address == SMAC_REG_TLOCK &&
			i_avs_writedata[7:0] == SMAC_TLOCK_KEY) begin
			s_next.lock = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_reg       <= '0;
			s_reg.st    <= ST_IDLE;
			s_reg.tbase <= SMAC_TBASE_RST;
			s_reg.wreq  <= 1'b1; // Idle bus stalls
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_cpu_done        = s_reg.done;
	assign o_phys_tgt        = s_reg.tgt;
	assign o_phys_addr       = s_reg.pa;
	assign o_exc             = s_reg.exc;
	assign o_exc_vec         = s_reg.vec;
	assign o_test_en         = s_reg.test_en;
	assign o_fetch_req       = s_reg.freq;
	assign o_fetch_addr      = s_reg.faddr;
	assign o_avs_readdata    = s_reg.rdata;
	assign o_avs_waitrequest = s_reg.wreq;

	// Checks on the controller's own behaviour
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	sequence user_take;
		s_reg.st == ST_IDLE && i_cpu_req && !s_reg.done &&
			i_cpu_mode == MODE_USER;
	endsequence
	sequence answered;
		o_cpu_done;
	endsequence

	AST_EXC_DONE: assert property (o_exc |-> o_cpu_done)
		else $error("trap without done");
	AST_EXC_VEC: assert property (o_exc |->
		o_exc_vec == SMAC_VEC_VIOL || o_exc_vec == SMAC_VEC_COLL)
		else $error("trap vector not fixed");
	AST_DONE_PULSE: assert property (o_cpu_done |=> !o_cpu_done)
		else $error("done longer than one cycle");
	AST_SCAN_TIME: assert property (user_take |-> ##67 answered)
		else $error("user check not answered in time");
	AST_EMPTY: assert property (s_reg.valid != '0 |->
		s_reg.loaded || s_reg.st == ST_LOAD)
		else $error("segment valid without load");
	AST_SEC_ROWS: assert property (o_cpu_done && !o_exc &&
		s_reg.user && o_phys_tgt == TGT_EE |-> o_phys_addr < SMAC_SEC_BASE)
		else $error("user reached protected rows");
	AST_LOCK_KEEP: assert property (locked |=> locked && !o_test_en)
		else $error("test lock released");
	AST_CFG_SYS: assert property (bus_req && i_avs_write &&
		i_cpu_mode != MODE_SYS |=> $stable(s_reg.tbase) && $stable(s_reg.lock))
		else $error("config written outside system mode");
	AST_FETCH_BASE: assert property ($rose(o_fetch_req) |->
		o_fetch_addr == s_reg.tbase)
		else $error("table fetch not at base");
	AST_COLL: assert property (s_reg.st == ST_LOAD && user_req |=>
		o_exc && o_exc_vec == SMAC_VEC_COLL)
		else $error("collision not trapped");
endmodule
`default_nettype wire

// ===== core/smac_pkg.sv
// Shared constants and types of the segment access controller
package smac_pkg;
	localparam int           SMAC_SEG_NUM  = 64;
	localparam int           SMAC_WORDS    = 2 * SMAC_SEG_NUM;
	localparam logic [15:0]  SMAC_ROM_SIZE = 16'h8000;
	localparam logic [15:0]  SMAC_EE_SIZE  = 16'h4000;
	localparam logic [15:0]  SMAC_RAM_SIZE = 16'h4000;
	localparam logic [15:0]  SMAC_SEC_ROWS = 16'h0080;
	localparam logic [15:0]  SMAC_SEC_BASE = SMAC_EE_SIZE - SMAC_SEC_ROWS;
	localparam logic [15:0]  SMAC_VEC_VIOL = 16'h0008;
	localparam logic [15:0]  SMAC_VEC_COLL = 16'h0010;
	localparam logic [2:0]   SMAC_GRP_TEST = 3'h7;
	localparam logic [7:0]   SMAC_REG_CTRL  = 8'h00;
	localparam logic [7:0]   SMAC_REG_TBASE = 8'h04;
	localparam logic [7:0]   SMAC_REG_STAT  = 8'h08;
	localparam logic [7:0]   SMAC_REG_FAULT = 8'h0c;
	localparam logic [7:0]   SMAC_REG_TLOCK = 8'h10;
	localparam logic [7:0]   SMAC_TLOCK_KEY = 8'ha5;
	localparam logic [15:0]  SMAC_TBASE_RST = 16'h0000;
	localparam logic [15:0]  SMAC_WORD_STEP = 16'h0004;
	typedef enum logic [1:0] {TGT_NONE, TGT_RAM, TGT_ROM, TGT_EE} smac_tgt_e;
	typedef enum logic [1:0] {MODE_SYS, MODE_USER, MODE_TEST, MODE_BOOT}
		smac_mode_e;
	typedef enum logic [1:0] {ACC_RD, ACC_WR, ACC_EX, ACC_RSV} smac_acc_e;
	// Descriptor: word0 [7:0] page,[15:8] pages,[17:16] tgt,[21:18] en x w r
	// word1 [15:0] physical base, [23:16] peripheral group grants
	typedef struct packed {
		logic        en;
		logic        ex;
		logic        wr;
		logic        rd;
		smac_tgt_e   tgt;
		logic [7:0]  npages;
		logic [7:0]  vpage;
		logic [15:0] pbase;
		logic [7:0]  sfr;
	} smac_desc_s;
endpackage

// ===== core/smac_seg_if.sv
// Segment store port between controller and descriptor memory
`timescale 1ns/1ps
`default_nettype none
interface smac_seg_if;
	import smac_pkg::*;
	logic       we;
	logic [5:0] waddr;
	smac_desc_s wdata;
	logic [5:0] raddr;
	smac_desc_s rdata;
	modport ctl (output we, waddr, wdata, raddr, input rdata);
	modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// ===== core/smac_seg_mem.sv
// Descriptor memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module smac_seg_mem #(
	parameter int DEPTH = smac_pkg::SMAC_SEG_NUM
) (
	input  wire logic  i_core_clk,
	smac_seg_if.mem    seg
);
	import smac_pkg::*;
	smac_desc_s mem_arr [DEPTH];
	smac_desc_s rd_reg;

	// No reset: entries are gated by the controller's valid bits
	always_ff @(posedge i_core_clk) begin
		if (seg.we) begin
			mem_arr[seg.waddr] <= seg.wdata;
		end
		rd_reg <= mem_arr[seg.raddr];
	end

	assign seg.rdata = rd_reg;
endmodule
`default_nettype wire

// ===== verif/smac_cpu_model.sv
// CPU-side partner model issuing virtual accesses
`timescale 1ns/1ps
`default_nettype none
module smac_cpu_model (
	input  wire logic                i_core_clk,
	input  wire logic                i_done,
	input  wire logic                i_exc,
	input  wire logic [15:0]         i_vec,
	input  wire logic [15:0]         i_pa,
	input  wire smac_pkg::smac_tgt_e i_tgt,
	output logic                     o_req,
	output logic [15:0]              o_addr,
	output logic [15:0]              o_pc,
	output var smac_pkg::smac_mode_e o_mode,
	output var smac_pkg::smac_acc_e  o_kind,
	output logic                     o_sfr,
	output logic [2:0]               o_grp
);
	import smac_pkg::*;
	// Idle in system mode from time zero
	initial begin
		o_req  = 1'b0;
		o_addr = 16'h0000;
		o_pc   = 16'h0000;
		o_mode = MODE_SYS;
		o_kind = ACC_RD;
		o_sfr  = 1'b0;
		o_grp  = 3'h0;
	end
	// Mode is a level, so it may change between accesses
	task automatic setm(input smac_mode_e m);
		o_mode <= m;
	endtask
	// Request held until the done pulse, then released
	task automatic acc(input smac_mode_e m, input smac_acc_e k,
		input logic [15:0] a, input logic [15:0] pc, input logic [3:0] sg,
		output logic e, output logic [15:0] v, output logic [15:0] p,
		output smac_tgt_e t);
		o_req  <= 1'b1;
		o_mode <= m;
		o_kind <= k;
		o_addr <= a;
		o_pc   <= pc;
		o_sfr  <= sg[3];
		o_grp  <= sg[2:0];
		do
			@(posedge i_core_clk);
		while (i_done !== 1'b1);
		e = i_exc;
		v = i_vec;
		p = i_pa;
		t = i_tgt;
		// Released address changes so stale values are never reused
		o_req  <= 1'b0;
		o_addr <= ~a;
		@(posedge i_core_clk);
	endtask
endmodule
`default_nettype wire

// ===== verif/smac_top_test.sv
// Self-checking bench of the segment access controller
`timescale 1ns/1ps
`default_nettype none
module smac_top_test;
	import smac_pkg::*;
	logic        clk, arst_n, req, sfr, done, exc, ten, freq, ack;
	logic        av_r, av_w, o_wait, fuse, freq_d;
	logic [15:0] addr, pc, pa, vec, faddr, fbase;
	logic [2:0]  grp;
	logic [7:0]  av_a;
	logic [31:0] av_d, o_rd, fdata;
	logic [31:0] tbl [128];
	smac_mode_e  mode;
	smac_acc_e   kind;
	smac_tgt_e   tgt;
	int          n_mismatch, comparisons, cyc;

	smac_top u_dut (.i_core_clk(clk), .i_arst_n(arst_n), .i_cpu_req(req),
		.i_cpu_addr(addr), .i_cpu_pc(pc), .i_cpu_mode(mode),
		.i_cpu_kind(kind), .i_cpu_sfr(sfr), .i_cpu_grp(grp),
		.o_cpu_done(done), .o_phys_tgt(tgt), .o_phys_addr(pa),
		.o_exc(exc), .o_exc_vec(vec), .o_test_en(ten),
		.o_fetch_req(freq), .o_fetch_addr(faddr), .i_fetch_ack(ack),
		.i_fetch_data(fdata), .i_test_fuse(fuse), .i_avs_address(av_a),
		.i_avs_read(av_r), .i_avs_write(av_w), .i_avs_writedata(av_d),
		.o_avs_readdata(o_rd), .o_avs_waitrequest(o_wait));
	smac_cpu_model u_cpu (.i_core_clk(clk), .i_done(done), .i_exc(exc),
		.i_vec(vec), .i_pa(pa), .i_tgt(tgt), .o_req(req), .o_addr(addr),
		.o_pc(pc), .o_mode(mode), .o_kind(kind), .o_sfr(sfr), .o_grp(grp));

	// Clock, reset and the two segments placed at table base 0x0400
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		av_r = 1'b0;
		av_w = 1'b0;
		av_a = 8'h00;
		av_d = 32'h0;
		ack = 1'b0;
		fuse = 1'b0;
		fdata = 32'h0;
		foreach (tbl[i])
			tbl[i] = 32'h0;
		tbl[0] = 32'h002501c0;
		tbl[1] = 32'h00020200;
		tbl[2] = 32'h003f4080;
		forever #2 clk = ~clk;
	end
	// Table memory: one ack per word, a cycle after each request
	always @(posedge clk) begin
		ack <= freq && !ack;
		fdata <= (freq && !ack) ? tbl[faddr[8:2]] : ~fdata;
		// First fetch address kept, it moves on after one word
		freq_d <= freq;
		if (freq && !freq_d)
			fbase <= faddr;
	end
	// Hang guard well above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic test_done();
		if (n_mismatch == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic bw(input logic [7:0] a, input logic [31:0] d);
		av_a <= a;
		av_d <= d;
		av_w <= 1'b1;
		do
			@(posedge clk);
		while (o_wait !== 1'b0);
		av_w <= 1'b0;
		@(posedge clk);
	endtask
	task automatic br(input logic [7:0] a, input logic [31:0] x);
		av_a <= a;
		av_r <= 1'b1;
		do
			@(posedge clk);
		while (o_wait !== 1'b0);
		chk(o_rd, x);
		av_r <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wfq(input logic lv);
		do
			@(posedge clk);
		while (freq !== lv);
	endtask
	// One access; on a trap the vector is checked, else target and offset
	task automatic ac(input smac_mode_e m, input smac_acc_e k,
		input logic [15:0] a, input logic [15:0] p, input logic [3:0] sg,
		input logic xe, input logic [15:0] xv, input smac_tgt_e xt);
		logic        e;
		logic [15:0] v;
		logic [15:0] q;
		smac_tgt_e   t;
		u_cpu.acc(m, k, a, p, sg, e, v, q, t);
		chk(32'(e), 32'(xe));
		chk(32'(xe ? v : q), 32'(xv));
		if (!xe)
			chk(32'(t), 32'(xt));
	endtask

	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		br(SMAC_REG_STAT, 32'h0);
		ac(MODE_USER, ACC_RD, 16'hc010, 16'hc000, 4'h0, 1, 16'h8, TGT_NONE);
		ac(MODE_SYS, ACC_RD, 16'h0010, 16'h0, 4'h0, 0, 16'h10, TGT_ROM);
		ac(MODE_SYS, ACC_WR, 16'h8010, 16'h0, 4'h0, 0, 16'h10, TGT_EE);
		ac(MODE_BOOT, ACC_WR, 16'hffff, 16'h0, 4'h0, 0, 16'h3fff, TGT_RAM);
		ac(MODE_SYS, ACC_WR, 16'h0045, 16'h0, 4'hf, 0, 16'h45, TGT_NONE);
		// Configuration from user mode must change nothing
		u_cpu.setm(MODE_USER);
		bw(SMAC_REG_CTRL, 32'h1);
		bw(SMAC_REG_TLOCK, 32'ha5);
		br(SMAC_REG_STAT, 32'h0);
		u_cpu.setm(MODE_SYS);
		bw(SMAC_REG_TBASE, 32'h0400);
		bw(SMAC_REG_CTRL, 32'h1);
		wfq(1'b1);
		chk(32'(fbase), 32'h0400);
		wfq(1'b0);
		br(SMAC_REG_STAT, 32'h2);
		ac(MODE_USER, ACC_RD, 16'hc010, 16'hc000, 4'h0, 0, 16'h210, TGT_RAM);
		ac(MODE_USER, ACC_WR, 16'hc010, 16'hc000, 4'h0, 1, 16'h8, TGT_NONE);
		ac(MODE_USER, ACC_EX, 16'h8010, 16'hc000, 4'h0, 0, 16'h10, TGT_EE);
		ac(MODE_USER, ACC_RSV, 16'h8010, 16'hc000, 4'h0, 1, 16'h8, TGT_NONE);
		ac(MODE_USER, ACC_RD, 16'hc110, 16'hc000, 4'h0, 1, 16'h8, TGT_NONE);
		ac(MODE_USER, ACC_RD, 16'h0010, 16'hc000, 4'h0, 1, 16'h8, TGT_NONE);
		ac(MODE_USER, ACC_RD, 16'hbf80, 16'hc000, 4'h0, 1, 16'h8, TGT_NONE);
		br(SMAC_REG_FAULT, 32'hbf80);
		ac(MODE_USER, ACC_RD, 16'h0045, 16'hc000, 4'h9, 0, 16'h45, TGT_NONE);
		ac(MODE_USER, ACC_RD, 16'h0045, 16'hc000, 4'ha, 1, 16'h8, TGT_NONE);
		ac(MODE_USER, ACC_RD, 16'h0045, 16'h8000, 4'h9, 1, 16'h8, TGT_NONE);
		// User access during a reload is a collision
		u_cpu.setm(MODE_SYS);
		bw(SMAC_REG_CTRL, 32'h1);
		ac(MODE_USER, ACC_RD, 16'hc010, 16'hc000, 4'h0, 1, 16'h10, TGT_NONE);
		wfq(1'b0);
		br(SMAC_REG_STAT, 32'ha);
		ac(MODE_USER, ACC_RD, 16'hc010, 16'hc000, 4'h0, 0, 16'h210, TGT_RAM);
		ac(MODE_TEST, ACC_RD, 16'h0045, 16'h0, 4'hf, 0, 16'h45, TGT_NONE);
		chk(32'(ten), 32'h1);
		u_cpu.setm(MODE_SYS);
		bw(SMAC_REG_TLOCK, 32'ha5);
		br(SMAC_REG_STAT, 32'he);
		u_cpu.setm(MODE_TEST);
		repeat (3) @(posedge clk);
		chk(32'(ten), 32'h0);
		ac(MODE_TEST, ACC_RD, 16'h0045, 16'h0, 4'hf, 1, 16'h8, TGT_NONE);
		br(8'h20, 32'h0);
		// Second reset drops every loaded segment
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'(o_wait), 32'h1);
		arst_n <= 1'b1;
		@(posedge clk);
		ac(MODE_USER, ACC_RD, 16'hc010, 16'hc000, 4'h0, 1, 16'h8, TGT_NONE);
		// Fuse pin alone locks test mode once reset cleared the key
		fuse <= 1'b1;
		repeat (3) @(posedge clk);
		br(SMAC_REG_STAT, 32'h4);
		ac(MODE_TEST, ACC_RD, 16'h0045, 16'h0, 4'hf, 1, 16'h8, TGT_NONE);
		test_done();
	end
endmodule
`default_nettype wire
